//--- tb/pmc_host_model.sv
// Configuration host model with the pulled-up clock-run wire.
`timescale 1ns/1ps
module pmc_host_model (
    // Clock.
    input wire logic i_clock,
    // Configuration request and answer.
    output logic o_req,
    output logic o_write,
    output logic [7:0] o_addr,
    output logic [3:0] o_be,
    output logic [31:0] o_wdata,
    input wire logic i_ack,
    input wire logic [31:0] i_rdata,
    // Clock-run wire.
    input wire logic i_dev_oe,
    output wire o_run_n
);
    logic hold_low = 1'b1;
    assign o_run_n = (i_dev_oe || hold_low) ? 1'b0 : 1'b1;
    initial begin
        o_req = 1'b0;
        o_write = 1'b0;
        o_addr = 8'h00;
        o_be = 4'h0;
        o_wdata = 32'h0;
    end
    task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d, output logic [31:0] q, output logic ok);
        @(posedge i_clock);
        o_req <= 1'b1;
        o_write <= w;
        o_addr <= a;
        o_be <= be;
        o_wdata <= d;
        @(posedge i_clock);
        o_req <= 1'b0;
        #1;
        ok = (i_ack === 1'b1);
        q = i_rdata;
    endtask : cfg
endmodule : pmc_host_model

//--- tb/pmc_misc_config_regs_sva.sv
// Port assertions for the configuration register block.
`timescale 1ns/1ps
module pmc_misc_config_regs_sva
    import pmc_pkg::*;
(
    // Clock, reset and configuration port.
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_cfg_req,
    input wire logic i_cfg_write,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [3:0] i_cfg_byte_en,
    input wire logic [31:0] i_cfg_wdata,
    input wire logic o_cfg_ack,
    input wire logic [31:0] o_cfg_rdata,
    input wire logic o_wake_from_cold_off,
    input wire logic o_wake_from_light_sleep,
    input wire logic o_light_sleep_supported,
    // Link access, pins and clock run.
    input wire logic i_link_req,
    input wire logic o_link_ack,
    input wire logic o_link_abort,
    input wire logic [31:0] o_link_rdata,
    input wire logic o_general_pin_three_oe,
    input wire logic o_serial_clock_in,
    input wire logic o_clock_run_n_oe
);
    logic rd_misc;
    logic rd_ext;
    assign rd_misc = i_cfg_req && !i_cfg_write && (i_cfg_addr[7:2] == PMC_MISC_DWORD);
    assign rd_ext = i_cfg_req && !i_cfg_write && (i_cfg_addr[7:2] == PMC_EXT_DWORD);
    default clocking dc @(posedge i_clock); endclocking
    default disable iff (i_rst);
    a_ack_follows: assert property (i_cfg_req |=> o_cfg_ack)
        else $error("Config request not acknowledged.");
    a_ext_zero: assert property (rd_ext |=> o_cfg_rdata == 32'h0)
        else $error("Extension word read not zero.");
    a_rsvd_zero: assert property (rd_misc |=> (o_cfg_rdata & 32'hffff5be0) == 32'h0)
        else $error("Reserved bit read as one.");
    a_caps_match: assert property (
        rd_misc |=> o_cfg_rdata[15] == o_wake_from_cold_off
        && o_cfg_rdata[13] == o_wake_from_light_sleep && o_cfg_rdata[10] == o_light_sleep_supported)
        else $error("Capability output differs from register.");
    a_cold_write: assert property (i_cfg_req && i_cfg_write && i_cfg_byte_en[1]
        && i_cfg_addr[7:2] == PMC_MISC_DWORD |=> o_wake_from_cold_off == $past(i_cfg_wdata[15]))
        else $error("Write did not reach capability bit.");
    a_link_answer: assert property (i_link_req |=> o_link_ack != o_link_abort)
        else $error("Link access not answered once.");
    a_abort_data: assert property (o_link_abort |-> o_link_rdata == 32'h0)
        else $error("Abort carried data.");
    a_pin_release: assert property (o_general_pin_three_oe |-> o_serial_clock_in)
        else $error("Serial clock not idle while pin driven.");
    a_run_hold: assert property (
        $rose(o_clock_run_n_oe) |=> o_clock_run_n_oe ##1 !o_clock_run_n_oe)
        else $error("Clock run pull not two cycles.");
endmodule : pmc_misc_config_regs_sva

//--- tb/pmc_misc_config_regs_tb_top.sv
// Self-checking testbench for the configuration register block.
`timescale 1ns/1ps
module pmc_misc_config_regs_tb_top;
    import pmc_pkg::*;
    logic i_clock = 1'b0, i_rst = 1'b1, i_link_req = 1'b0, i_link_clock_active = 1'b1;
    logic i_general_pin_three = 1'b1, i_general_pin_two = 1'b1;
    logic [31:0] i_link_reg_rdata = 32'h0;
    logic [1:0] i_gpio_out = 2'h3, i_gpio_oe = 2'h3;
    logic i_cfg_req, i_cfg_write, o_cfg_ack, o_wake_from_cold_off;
    logic [7:0] i_cfg_addr;
    logic [3:0] i_cfg_byte_en;
    logic [31:0] i_cfg_wdata, o_cfg_rdata, o_link_rdata, q;
    logic o_wake_from_light_sleep, o_light_sleep_supported, o_link_ack, o_link_abort;
    logic o_link_clock_gating_bypass, o_pci_clock_gating_bypass, ok;
    logic o_general_pin_three, o_general_pin_three_oe, o_general_pin_two, o_general_pin_two_oe;
    logic [1:0] o_gpio_in;
    logic o_serial_clock_in, o_serial_data_in, o_clock_run_n, o_clock_run_n_oe;
    wire i_clock_run_n;
    logic [2:0] caps;
    logic [1:0] bypass;
    logic [3:0] pins;
    int failures = 0;
    int n_compared = 0;

    pmc_misc_config_regs uut (.*);
    pmc_host_model host (.i_clock(i_clock), .o_req(i_cfg_req), .o_write(i_cfg_write),
        .o_addr(i_cfg_addr), .o_be(i_cfg_byte_en), .o_wdata(i_cfg_wdata), .i_ack(o_cfg_ack),
        .i_rdata(o_cfg_rdata), .i_dev_oe(o_clock_run_n_oe), .o_run_n(i_clock_run_n));

    assign caps = {o_wake_from_cold_off, o_wake_from_light_sleep, o_light_sleep_supported};
    assign bypass = {o_link_clock_gating_bypass, o_pci_clock_gating_bypass};
    assign pins = {o_general_pin_three_oe, o_general_pin_two_oe,
        o_serial_clock_in, o_serial_data_in};

    always #2.5 i_clock = ~i_clock;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        host.cfg(1'b1, a, be, d, q, ok);
        chk(32'(ok), 32'h1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        host.cfg(1'b0, a, 4'hf, 32'h0, q, ok);
        chk(32'(ok), 32'h1);
        chk(q, exp);
    endtask : rd

    task automatic link(input logic [31:0] d, input logic [1:0] ans, input logic [31:0] exp);
        @(posedge i_clock);
        i_link_req <= 1'b1;
        i_link_reg_rdata <= d;
        @(posedge i_clock);
        i_link_req <= 1'b0;
        #1;
        chk(32'({o_link_ack, o_link_abort}), 32'(ans));
        chk(o_link_rdata, exp);
    endtask : link

    task automatic t_reset_and_ext;
        rd(8'hf0, PMC_MISC_RESET);
        chk(32'(caps), 32'h3);
        wr(8'h48, 4'hf, 32'hffffffff);
        rd(8'h4a, 32'h0);
        rd(8'hf0, PMC_MISC_RESET);
        rd(8'h80, 32'h0);
    endtask : t_reset_and_ext

    task automatic t_write_mask;
        wr(8'hf0, 4'hf, 32'hffffffff);
        rd(8'hf0, PMC_MISC_WRITE_MASK);
        chk(32'(caps), 32'h7);
        chk(32'(bypass), 32'h3);
        wr(8'hf0, 4'h2, 32'h0);
        rd(8'hf0, 32'h1f);
        chk(32'(caps), 32'h0);
        wr(8'hf0, 4'hf, 32'h10);
        chk(32'(bypass), 32'h0);
    endtask : t_write_mask

    task automatic t_link;
        @(posedge i_clock);
        i_link_clock_active <= 1'b0;
        repeat (6) @(posedge i_clock);
        wr(8'hf0, 4'hf, 32'h0);
        link(32'h12345678, 2'b01, 32'h0);
        wr(8'hf0, 4'hf, 32'h10);
        link(32'h12345678, 2'b10, PMC_INACTIVE_FILL);
        @(posedge i_clock);
        i_link_clock_active <= 1'b1;
        repeat (6) @(posedge i_clock);
        link(32'h12345678, 2'b10, 32'h12345678);
    endtask : t_link

    task automatic t_reroute;
        wr(8'hf0, 4'hf, 32'h18);
        @(posedge i_clock);
        i_general_pin_three <= 1'b0;
        i_gpio_out <= 2'h2;
        repeat (6) @(posedge i_clock);
        #1;
        chk(32'(pins), 32'h1);
        chk(32'(o_gpio_in), 32'h1);
        chk(32'({o_general_pin_three, o_general_pin_two}), 32'h2);
        wr(8'hf0, 4'hf, 32'h10);
        @(posedge i_clock);
        #1;
        chk(32'(pins), 32'hf);
        @(posedge i_clock);
        i_general_pin_three <= 1'b1;
        i_gpio_out <= 2'h3;
    endtask : t_reroute

    task automatic t_clock_run;
        int k;
        int n;
        host.hold_low <= 1'b0;
        n = 0;
        repeat (12) begin
            @(posedge i_clock);
            #1;
            n += int'(o_clock_run_n_oe === 1'b1);
        end
        chk(32'(n), 32'h0);
        wr(8'hf0, 4'hf, 32'h11);
        k = 0;
        n = 0;
        while (o_clock_run_n_oe !== 1'b1 && k < 20) begin
            @(posedge i_clock);
            #1;
            k++;
        end
        chk(32'(o_clock_run_n_oe), 32'h1);
        while (o_clock_run_n_oe === 1'b1 && n < 8) begin
            chk(32'(i_clock_run_n), 32'h0);
            chk(32'(o_clock_run_n), 32'h0);
            @(posedge i_clock);
            #1;
            n++;
        end
        chk(32'(n), 32'h2);
        @(posedge i_clock);
        host.hold_low <= 1'b1;
    endtask : t_clock_run

    task automatic report_and_stop;
        $display("Comparisons %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (5) @(posedge i_clock);
        i_rst <= 1'b0;
        t_reset_and_ext();
        t_write_mask();
        t_link();
        t_reroute();
        t_clock_run();
        report_and_stop();
    end
endmodule : pmc_misc_config_regs_tb_top

bind pmc_misc_config_regs pmc_misc_config_regs_sva u_sva (
    .i_clock(i_clock), .i_rst(i_rst), .i_cfg_req(i_cfg_req), .i_cfg_write(i_cfg_write),
    .i_cfg_addr(i_cfg_addr), .i_cfg_byte_en(i_cfg_byte_en), .i_cfg_wdata(i_cfg_wdata),
    .o_cfg_ack(o_cfg_ack), .o_cfg_rdata(o_cfg_rdata),
    .o_wake_from_cold_off(o_wake_from_cold_off),
    .o_wake_from_light_sleep(o_wake_from_light_sleep),
    .o_light_sleep_supported(o_light_sleep_supported), .i_link_req(i_link_req),
    .o_link_ack(o_link_ack), .o_link_abort(o_link_abort), .o_link_rdata(o_link_rdata),
    .o_general_pin_three_oe(o_general_pin_three_oe), .o_serial_clock_in(o_serial_clock_in),
    .o_clock_run_n_oe(o_clock_run_n_oe)
);

//--- verilog/pmc_misc_config_regs.sv
// Power-management extension and miscellaneous configuration registers.
//
// Contract
// - Extension word is read-only, always reads zero, writes ignored.
// - Extension upper byte, power report data, always reads zero.
// - Extension lower byte, bridge support extensions, always reads zero.
// - Reserved miscellaneous bits 31-16, 14, 12-11, 9-5 read zero.
// - Bit 15 supplies capability bit 15, wake from cold off.
// - Bit 13 supplies capability bit 13, wake from light sleep.
// - Bit 10 supplies capability bit 10, light sleep supported.
// - Suppression zero: stopped-clock link access answered with target abort.
// - Suppression one: stopped-clock link access completes returning all ones.
// - Rerouting one: pins three and two feed serial clock and data, undriven.
// - Link clock gating bypass one lets link clock run ungated; test only.
// - PCI clock gating bypass one lets PCI clock run ungated; test only.
// - Clock-run request one: device keeps PCI clock running via clock-run.
// - Clock-run request zero: device lets PCI clock be stopped.
`timescale 1ns/1ps
module pmc_misc_config_regs
    import pmc_pkg::*;
(
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst,

    // Configuration access port.
    input wire logic i_cfg_req,
    input wire logic i_cfg_write,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [3:0] i_cfg_byte_en,
    input wire logic [31:0] i_cfg_wdata,
    output logic o_cfg_ack,
    output logic [31:0] o_cfg_rdata,

    // Capability bits fed to the capabilities register.
    output logic o_wake_from_cold_off,
    output logic o_wake_from_light_sleep,
    output logic o_light_sleep_supported,

    // Access to registers of the serial-link clock domain.
    input wire logic i_link_req,
    input wire logic [31:0] i_link_reg_rdata,
    input wire logic i_link_clock_active,
    output logic o_link_ack,
    output logic o_link_abort,
    output logic [31:0] o_link_rdata,

    // Clock gating controls.
    output logic o_link_clock_gating_bypass,
    output logic o_pci_clock_gating_bypass,

    // General pins three and two.
    input wire logic i_general_pin_three,
    input wire logic i_general_pin_two,
    output logic o_general_pin_three,
    output logic o_general_pin_three_oe,
    output logic o_general_pin_two,
    output logic o_general_pin_two_oe,

    // General-purpose logic side of the pins.
    input wire logic [1:0] i_gpio_out,
    input wire logic [1:0] i_gpio_oe,
    output logic [1:0] o_gpio_in,

    // Serial bus side of the rerouted pins.
    output logic o_serial_clock_in,
    output logic o_serial_data_in,

    // Clock-run open-drain pin, active low.
    input wire logic i_clock_run_n,
    output logic o_clock_run_n,
    output logic o_clock_run_n_oe
);

    logic [31:0] misc_reg;
    logic [31:0] misc_next;
    logic [15:0] ext_word;
    logic cfg_ack_reg;
    logic [31:0] cfg_rdata_reg;
    logic [31:0] cfg_rdata_next;
    logic cfg_misc_hit;
    logic cfg_ext_hit;
    logic link_ack_reg;
    logic link_abort_reg;
    logic [31:0] link_rdata_reg;
    logic [PMC_SYNC_COUNT-1:0] pin_raw;
    logic [PMC_SYNC_COUNT-1:0] pin_clean;
    logic abort_suppression;
    logic pin_rerouting;
    logic clock_run_request;
    pmc_clock_run_state_t cr_state_reg;
    pmc_clock_run_state_t cr_state_next;
    logic [1:0] cr_count_reg;
    logic cr_drive_reg;
    logic pin_two_out_reg;
    logic pin_three_out_reg;
    logic pin_two_oe_reg;
    logic pin_three_oe_reg;
    logic serial_clock_reg;
    logic serial_data_reg;

    // Pin inputs from outside the clock domain.
    assign pin_raw[PMC_SYNC_PIN_TWO] = i_general_pin_two;
    assign pin_raw[PMC_SYNC_PIN_THREE] = i_general_pin_three;
    assign pin_raw[PMC_SYNC_CLOCK_RUN] = i_clock_run_n;
    assign pin_raw[PMC_SYNC_LINK_ACTIVE] = i_link_clock_active;

    // One filtered synchroniser per incoming pin.
    generate
        for (genvar g = 0; g < PMC_SYNC_COUNT; g++) begin : g_sync
            pmc_sync_if sync_if ();

            assign sync_if.raw = pin_raw[g];
            assign pin_clean[g] = sync_if.clean;

            pmc_pin_filter #(
                .p_reset_level(PMC_SYNC_RESET[g])
            ) u_filter (
                .i_clock(i_clock),
                .i_rst(i_rst),
                .sync(sync_if.filter)
            );
        end
    endgenerate

    // Field views of the miscellaneous configuration word.
    assign abort_suppression = misc_reg[PMC_ABORT_SUPPRESSION_BIT];
    assign pin_rerouting = misc_reg[PMC_PIN_REROUTING_BIT];
    assign clock_run_request = misc_reg[PMC_CLOCK_RUN_REQUEST_BIT];

    // Extension word is built from constant zero fields.
    assign ext_word = {PMC_POWER_REPORT_DATA, PMC_BRIDGE_SUPPORT_EXTENSIONS};

    // Configuration address decode.
    assign cfg_misc_hit = (i_cfg_addr[7:2] == PMC_MISC_DWORD);
    assign cfg_ext_hit = (i_cfg_addr[7:2] == PMC_EXT_DWORD);

    // Byte-enabled write that touches only writable bits.
    always_comb begin
        misc_next = misc_reg;
        if (i_cfg_req && i_cfg_write && cfg_misc_hit) begin
            for (int b = 0; b < 4; b++) begin
                if (i_cfg_byte_en[b]) begin
                    misc_next[b*8 +: 8] = (i_cfg_wdata[b*8 +: 8] & PMC_MISC_WRITE_MASK[b*8 +: 8])
                        | (misc_reg[b*8 +: 8] & ~PMC_MISC_WRITE_MASK[b*8 +: 8]);
                end
            end
        end
    end

    // Miscellaneous configuration storage; reserved bits never leave zero.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            misc_reg <= PMC_MISC_RESET;
        end else begin
            misc_reg <= misc_next & PMC_MISC_WRITE_MASK;
        end
    end

    // Read data selection; writes to the extension word are dropped.
    always_comb begin
        cfg_rdata_next = 32'h00000000;
        if (cfg_misc_hit) begin
            cfg_rdata_next = misc_reg & PMC_MISC_WRITE_MASK;
        end else if (cfg_ext_hit) begin
            cfg_rdata_next = {ext_word, 16'h0000} >> (PMC_EXT_SHIFT - 16);
        end
    end

    // Configuration answer one cycle after the request.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cfg_ack_reg <= 1'b0;
            cfg_rdata_reg <= 32'h00000000;
        end else begin
            cfg_ack_reg <= i_cfg_req;
            if (i_cfg_req && !i_cfg_write) begin
                cfg_rdata_reg <= cfg_rdata_next;
            end
        end
    end

    assign o_cfg_ack = cfg_ack_reg;
    assign o_cfg_rdata = cfg_rdata_reg;

    // Capability bits follow the stored fields.
    assign o_wake_from_cold_off = misc_reg[PMC_WAKE_FROM_COLD_OFF_BIT];
    assign o_wake_from_light_sleep = misc_reg[PMC_WAKE_FROM_LIGHT_SLEEP_BIT];
    assign o_light_sleep_supported = misc_reg[PMC_LIGHT_SLEEP_SUPPORTED_BIT];

    // Answer to accesses of the serial-link clock domain.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            link_ack_reg <= 1'b0;
            link_abort_reg <= 1'b0;
            link_rdata_reg <= 32'h00000000;
        end else begin
            link_ack_reg <= 1'b0;
            link_abort_reg <= 1'b0;
            if (i_link_req) begin
                if (pin_clean[PMC_SYNC_LINK_ACTIVE]) begin
                    link_ack_reg <= 1'b1;
                    link_rdata_reg <= i_link_reg_rdata;
                end else if (abort_suppression) begin
                    link_ack_reg <= 1'b1;
                    link_rdata_reg <= PMC_INACTIVE_FILL;
                end else begin
                    link_abort_reg <= 1'b1;
                    link_rdata_reg <= 32'h00000000;
                end
            end
        end
    end

    assign o_link_ack = link_ack_reg;
    assign o_link_abort = link_abort_reg;
    assign o_link_rdata = link_rdata_reg;

    // Clock gating bypass controls.
    assign o_link_clock_gating_bypass = misc_reg[PMC_LINK_CLOCK_GATING_BYPASS_BIT];
    assign o_pci_clock_gating_bypass = misc_reg[PMC_PCI_CLOCK_GATING_BYPASS_BIT];

    // Pin drivers and serial levels switch at one edge, so a driven pin always meets idle serial levels.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pin_two_out_reg <= 1'b0;
            pin_three_out_reg <= 1'b0;
            pin_two_oe_reg <= 1'b0;
            pin_three_oe_reg <= 1'b0;
            serial_clock_reg <= 1'b1;
            serial_data_reg <= 1'b1;
        end else begin
            pin_two_out_reg <= i_gpio_out[0];
            pin_three_out_reg <= i_gpio_out[1];
            pin_two_oe_reg <= i_gpio_oe[0] && !pin_rerouting;
            pin_three_oe_reg <= i_gpio_oe[1] && !pin_rerouting;
            serial_clock_reg <= pin_rerouting ? pin_clean[PMC_SYNC_PIN_THREE] : 1'b1;
            serial_data_reg <= pin_rerouting ? pin_clean[PMC_SYNC_PIN_TWO] : 1'b1;
        end
    end

    // Pin levels towards general-purpose logic and the serial bus.
    assign o_general_pin_two = pin_two_out_reg;
    assign o_general_pin_three = pin_three_out_reg;
    assign o_general_pin_two_oe = pin_two_oe_reg;
    assign o_general_pin_three_oe = pin_three_oe_reg;
    assign o_gpio_in = {pin_clean[PMC_SYNC_PIN_THREE], pin_clean[PMC_SYNC_PIN_TWO]};
    assign o_serial_clock_in = serial_clock_reg;
    assign o_serial_data_in = serial_data_reg;

    // Clock-run request sequencing.
    always_comb begin
        cr_state_next = cr_state_reg;
        unique case (cr_state_reg)
            PMC_CR_IDLE: begin
                if (clock_run_request && pin_clean[PMC_SYNC_CLOCK_RUN]) begin
                    cr_state_next = PMC_CR_HOLD;
                end
            end
            PMC_CR_HOLD: begin
                if (cr_count_reg == 2'h1) begin
                    cr_state_next = PMC_CR_WAIT;
                end
            end
            PMC_CR_WAIT: begin
                if (!pin_clean[PMC_SYNC_CLOCK_RUN]) begin
                    cr_state_next = PMC_CR_IDLE;
                end
            end
            default: begin
                cr_state_next = PMC_CR_IDLE;
            end
        endcase
    end

    // Clock-run state register.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cr_state_reg <= PMC_CR_IDLE;
        end else begin
            cr_state_reg <= cr_state_next;
        end
    end

    // Hold counter for the low drive of the clock-run pin.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cr_count_reg <= 2'h0;
        end else if (cr_state_reg == PMC_CR_IDLE) begin
            cr_count_reg <= PMC_CLOCK_RUN_HOLD_CYCLES;
        end else if (cr_count_reg != 2'h0) begin
            cr_count_reg <= cr_count_reg - 2'h1;
        end
    end

    // Low drive only while holding; stops one cycle after the request bit is cleared.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cr_drive_reg <= 1'b0;
        end else begin
            cr_drive_reg <= (cr_state_next == PMC_CR_HOLD) && clock_run_request;
        end
    end

    assign o_clock_run_n = 1'b0;
    assign o_clock_run_n_oe = cr_drive_reg;

endmodule : pmc_misc_config_regs

//--- verilog/pmc_pin_filter.sv
// Three-flop synchroniser with agreement filter for one pin input.
`timescale 1ns/1ps
module pmc_pin_filter #(
    parameter logic p_reset_level = 1'b1
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst,
    // Pin level in and filtered level out.
    pmc_sync_if.filter sync
);

    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;
    logic clean_reg;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            stage1_reg <= p_reset_level;
            stage2_reg <= p_reset_level;
            stage3_reg <= p_reset_level;
        end else begin
            stage1_reg <= sync.raw;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // A change is taken once the second and third stages agree.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            clean_reg <= p_reset_level;
        end else if (stage2_reg == stage3_reg) begin
            clean_reg <= stage3_reg;
        end
    end

    assign sync.clean = clean_reg;

endmodule : pmc_pin_filter

//--- verilog/pmc_pkg.sv
// Constants for the power-management extension and miscellaneous configuration registers.
package pmc_pkg;

    // Configuration space byte offsets.
    localparam logic [7:0] PMC_EXT_OFFSET = 8'h4a;
    localparam logic [7:0] PMC_MISC_OFFSET = 8'hf0;

    // Dword indices used by the configuration decode.
    localparam logic [5:0] PMC_EXT_DWORD = PMC_EXT_OFFSET[7:2];
    localparam logic [5:0] PMC_MISC_DWORD = PMC_MISC_OFFSET[7:2];

    // Bit position of the extension word inside its dword.
    localparam int PMC_EXT_SHIFT = 16;

    // Extension word fields and values.
    localparam logic [7:0] PMC_POWER_REPORT_DATA = 8'h00;
    localparam logic [7:0] PMC_BRIDGE_SUPPORT_EXTENSIONS = 8'h00;
    localparam logic [15:0] PMC_EXT_RESET = 16'h0000;

    // Miscellaneous configuration fields.
    localparam int PMC_WAKE_FROM_COLD_OFF_BIT = 15;
    localparam int PMC_WAKE_FROM_LIGHT_SLEEP_BIT = 13;
    localparam int PMC_LIGHT_SLEEP_SUPPORTED_BIT = 10;
    localparam int PMC_ABORT_SUPPRESSION_BIT = 4;
    localparam int PMC_PIN_REROUTING_BIT = 3;
    localparam int PMC_LINK_CLOCK_GATING_BYPASS_BIT = 2;
    localparam int PMC_PCI_CLOCK_GATING_BYPASS_BIT = 1;
    localparam int PMC_CLOCK_RUN_REQUEST_BIT = 0;

    // Writable mask and reset value of the miscellaneous configuration word.
    localparam logic [31:0] PMC_MISC_WRITE_MASK = 32'h0000a41f;
    localparam logic [31:0] PMC_MISC_RESET = 32'h00002400;

    // Data returned for an access to the stopped serial-link clock domain.
    localparam logic [31:0] PMC_INACTIVE_FILL = 32'hffffffff;

    // Synchronised pin inputs.
    localparam int PMC_SYNC_COUNT = 4;
    localparam int PMC_SYNC_PIN_TWO = 0;
    localparam int PMC_SYNC_PIN_THREE = 1;
    localparam int PMC_SYNC_CLOCK_RUN = 2;
    localparam int PMC_SYNC_LINK_ACTIVE = 3;
    localparam logic [PMC_SYNC_COUNT-1:0] PMC_SYNC_RESET = 4'hf;

    // Clock-run hold time in cycles of the 200 MHz clock.
    localparam logic [1:0] PMC_CLOCK_RUN_HOLD_CYCLES = 2'h2;

    // Clock-run request states.
    typedef enum logic [1:0] {
        PMC_CR_IDLE = 2'b00,
        PMC_CR_HOLD = 2'b01,
        PMC_CR_WAIT = 2'b10
    } pmc_clock_run_state_t;

endpackage : pmc_pkg

//--- verilog/pmc_sync_if.sv
// Carrier between a raw pin input and its filtered level.
`timescale 1ns/1ps
interface pmc_sync_if;
    logic raw;
    logic clean;
    modport filter (input raw, output clean);
    modport user (output raw, input clean);
endinterface : pmc_sync_if
